// >>> design/tick_timer_8_16.sv
// 8/16-bit tick timer with prescaler, postscaler and APB register access
// Functional notes
// - Width select bit picks 8 or 16 bits
// - Quarter clock source counts each instruction cycle
// - Low byte read copies high count
// - Low byte write loads high from buffer
// - 8-bit match pulses output, clears count
// - Reset clears low, sets period all ones
// - Count or control writes clear scalers
// - Prescaler divides by powers of two
// - Postscaler divides by one to sixteen
// - Event is period match or rollover
// - Flag set every postscale plus one events
// - Async mode counts raw, runs in sleep
// - Sync mode aligns count to instruction clock
// - Sleep halts sync timer, async may wake
// - Enabled flag interrupts and wakes processor
// - Three-bit field selects clock source
// - Output toggles per postscaled event
// - Output state readable in control zero
// - Zero prescale select bypasses prescaler
// - 8-bit registers read and write directly
`timescale 1ns/1ns
module tick_timer_8_16 (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources and power state
  input wire logic [tick_timer_pkg::SRC_N-1:0] src_in,
  input wire logic sleep_mode,
  // Timer outputs
  output logic tick_output,
  output logic match_pulse,
  output logic irq_out,
  output logic wake_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] hbuf;
    logic [7:0] pbuf;
    logic [7:0] hsnap;
    tick_timer_pkg::ctrl0_s c0;
    tick_timer_pkg::ctrl1_s c1;
    logic flag;
    logic ie;
    logic irq;
    logic wake;
    logic tout;
    logic mpulse;
    logic [1:0] div;
    logic pend;
    logic [tick_timer_pkg::SRC_N-1:0] src_prev;
    logic ready;
    logic err;
    logic [31:0] rdata;
  } timer_state_s;

  timer_state_s r;
  timer_state_s n;

  logic instr_tick;
  logic [tick_timer_pkg::SRC_N-1:0] src_edge;
  logic src_pick;
  logic sleep_hold;
  logic pre_in;
  logic pre_out;
  logic step;
  logic consume;
  logic [15:0] wide_cnt;
  logic match8;
  logic roll16;
  logic tmr_ev;
  logic post_ev;
  logic acc;
  logic wait_cyc;
  logic commit;
  logic wr;
  logic rd;
  logic clr;
  logic [31:0] rd_word;

  function automatic logic mapped(input logic [7:0] a);
    return a == tick_timer_pkg::OFS_COUNT_LOW || a == tick_timer_pkg::OFS_HIGH_PERIOD ||
      a == tick_timer_pkg::OFS_CTRL_ZERO || a == tick_timer_pkg::OFS_CTRL_ONE ||
      a == tick_timer_pkg::OFS_STATUS;
  endfunction : mapped

  // ==========================================================
  // Clock source selection
  assign instr_tick = r.div == tick_timer_pkg::INSTR_LAST;
  assign src_edge = src_in & ~r.src_prev;
  assign src_pick = (r.c1.clk_sel == tick_timer_pkg::SRC_INSTR) ? instr_tick :
    src_edge[3'(r.c1.clk_sel - 3'h1)];
  // Sleep stops the instruction clock, so a synchronous timer sees no edges
  assign sleep_hold = sleep_mode & ~r.c1.async_sel;
  assign pre_in = src_pick & ~sleep_hold;

  tick_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clr),
    .sel(r.c1.pre_sel),
    .in_tick(pre_in),
    .out_tick(pre_out)
  );

  // Sync mode holds a prescaled edge until the next instruction cycle;
  // edges faster than that rate merge, which is why the source must be slower
  assign consume = instr_tick & ~sleep_mode;
  assign step = r.c1.async_sel ? pre_out : (r.pend & consume);

  // ==========================================================
  // Event detection
  assign wide_cnt = {r.hi, r.lo};
  assign match8 = r.lo == r.pbuf;
  assign roll16 = wide_cnt == tick_timer_pkg::WIDE_ALL_ONES;
  assign tmr_ev = step & (r.c0.wide ? roll16 : match8);

  tick_postscaler u_post (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clr),
    .sel(r.c0.post_sel),
    .in_ev(tmr_ev),
    .out_ev(post_ev)
  );

  // ==========================================================
  // APB decode: one wait state, the answer is registered
  assign acc = psel & penable;
  assign wait_cyc = acc & ~r.ready;
  assign commit = acc & r.ready;
  assign wr = commit & pwrite & mapped(paddr);
  assign rd = commit & ~pwrite & mapped(paddr);
  assign clr = wr & (paddr == tick_timer_pkg::OFS_COUNT_LOW ||
    paddr == tick_timer_pkg::OFS_CTRL_ZERO || paddr == tick_timer_pkg::OFS_CTRL_ONE);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      tick_timer_pkg::OFS_COUNT_LOW: rd_word = {24'h00_0000, r.lo};
      tick_timer_pkg::OFS_HIGH_PERIOD: rd_word = {24'h00_0000, r.hbuf};
      tick_timer_pkg::OFS_CTRL_ZERO: rd_word = {26'h000_0000, r.tout, r.c0};
      tick_timer_pkg::OFS_CTRL_ONE: rd_word = {24'h00_0000, r.c1};
      tick_timer_pkg::OFS_STATUS: rd_word = {30'h0000_0000, r.ie, r.flag};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    n = r;
    n.div = r.div + 2'h1;
    n.src_prev = src_in;
    n.pend = r.c1.async_sel ? 1'b0 : (pre_out | (r.pend & ~consume));
    // Counting
    if (step) begin
      n.mpulse = 1'b0;
      if (r.c0.wide) begin
        {n.hi, n.lo} = 16'(wide_cnt + 16'h0001);
      end else if (match8) begin
        n.lo = 8'h00;
        n.pbuf = r.hbuf;
        n.mpulse = 1'b1;
      end else begin
        n.lo = r.lo + 8'h01;
      end
    end
    // Bus answer
    n.ready = wait_cyc;
    if (wait_cyc) begin
      n.rdata = rd_word;
      n.err = ~mapped(paddr);
      n.hsnap = r.hi;
    end
    // Read side effect uses the high byte caught with the low byte
    if (rd && paddr == tick_timer_pkg::OFS_COUNT_LOW && r.c0.wide) begin
      n.hbuf = r.hsnap;
    end
    // Writes override counting in the same cycle
    if (wr) begin
      unique case (paddr)
        tick_timer_pkg::OFS_COUNT_LOW: begin
          n.lo = pwdata[7:0];
          if (r.c0.wide) begin
            n.hi = r.hbuf;
          end
        end
        tick_timer_pkg::OFS_HIGH_PERIOD: begin
          n.hbuf = pwdata[7:0];
        end
        tick_timer_pkg::OFS_CTRL_ZERO: begin
          n.c0.wide = pwdata[tick_timer_pkg::C0_WIDE_BIT];
          n.c0.post_sel = pwdata[3:0];
        end
        tick_timer_pkg::OFS_CTRL_ONE: begin
          n.c1 = pwdata[7:0];
        end
        tick_timer_pkg::OFS_STATUS: begin
          if (pwdata[tick_timer_pkg::STAT_FLAG_BIT]) begin
            n.flag = 1'b0;
          end
          n.ie = pwdata[tick_timer_pkg::STAT_IE_BIT];
        end
        default: begin
        end
      endcase
    end
    // A postscaled event beats a clear in the same cycle
    if (post_ev) begin
      n.flag = 1'b1;
      n.tout = ~r.tout;
    end
    n.irq = r.flag & r.ie;
    n.wake = r.flag & r.ie & sleep_mode;
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.lo <= tick_timer_pkg::RST_COUNT_LOW;
      r.hbuf <= tick_timer_pkg::RST_HIGH_PERIOD;
      r.pbuf <= tick_timer_pkg::RST_HIGH_PERIOD;
      r.hi <= tick_timer_pkg::RST_COUNT_HIGH;
      r.c0 <= tick_timer_pkg::RST_CTRL0;
      r.c1 <= tick_timer_pkg::RST_CTRL1;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.err;
  assign tick_output = r.tout;
  assign match_pulse = r.mpulse;
  assign irq_out = r.irq;
  assign wake_out = r.wake;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait;
    psel && penable && !pready;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  property p_apb_answer;
    s_wait |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer not one wait state");

  property p_match8;
    (step && !r.c0.wide && match8 && !wr) |=> (r.lo == 8'h00 && match_pulse);
  endproperty
  a_match8: assert property (p_match8) else $error("8-bit match did not clear and pulse");

  property p_period_copy;
    (step && !r.c0.wide && match8 && !wr) |=> (r.pbuf == $past(r.hbuf));
  endproperty
  a_period_copy: assert property (p_period_copy) else $error("period buffer not loaded");

  property p_read_copy;
    (rd && paddr == tick_timer_pkg::OFS_COUNT_LOW && r.c0.wide) |=> (r.hbuf == $past(r.hsnap));
  endproperty
  a_read_copy: assert property (p_read_copy) else $error("high byte not copied on read");

  property p_write_load;
    (wr && paddr == tick_timer_pkg::OFS_COUNT_LOW && r.c0.wide) |=> (r.hi == $past(r.hbuf));
  endproperty
  a_write_load: assert property (p_write_load) else $error("high byte not loaded on write");

  property p_flag_set;
    post_ev |=> r.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag missed a postscaled event");

  property p_toggle;
    post_ev |=> (tick_output != $past(tick_output));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle");

  property p_irq;
    (r.flag && r.ie) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_sleep_halt;
    (sleep_mode && !r.c1.async_sel) |-> !step;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sync timer counted in sleep");

  property p_roll16;
    (step && r.c0.wide && roll16 && !wr) |=> (r.lo == 8'h00 && r.hi == 8'h00);
  endproperty
  a_roll16: assert property (p_roll16) else $error("16-bit rollover wrong");

  property p_wake;
    (r.flag && r.ie && sleep_mode) |=> wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not raised in sleep");

  property p_irq_masked;
    !r.ie |=> !irq_out;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while disabled");

  property p_async_step;
    (r.c1.async_sel && pre_out) |-> step;
  endproperty
  a_async_step: assert property (p_async_step) else $error("async prescaled edge did not count");

  // A synchronous count may only land on an instruction cycle
  property p_sync_rate;
    (!r.c1.async_sel && step) |-> instr_tick;
  endproperty
  a_sync_rate: assert property (p_sync_rate) else $error("sync count off the instruction cycle");

  property p_count8;
    (step && !r.c0.wide && !match8 && !wr) |=> (r.lo == 8'($past(r.lo) + 8'h01));
  endproperty
  a_count8: assert property (p_count8) else $error("8-bit count did not advance by one");

  property p_high_hold8;
    !r.c0.wide |=> (r.hi == $past(r.hi));
  endproperty
  a_high_hold8: assert property (p_high_hold8) else $error("high count moved in 8-bit mode");

endmodule : tick_timer_8_16

// >>> design/tick_timer_pkg.sv
// Shared constants and carrier types for the 8/16-bit tick timer
package tick_timer_pkg;

  // ==========================================================
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFS_HIGH_PERIOD = 8'h04;
  localparam logic [7:0] OFS_CTRL_ZERO = 8'h08;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ==========================================================
  // Field positions
  localparam int C0_OUT_BIT = 5;
  localparam int C0_WIDE_BIT = 4;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_IE_BIT = 1;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] RST_COUNT_LOW = 8'h00;
  localparam logic [7:0] RST_HIGH_PERIOD = 8'hff;
  localparam logic [7:0] RST_COUNT_HIGH = 8'h00;

  // ==========================================================
  // Counts and encodings
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam logic [2:0] SRC_INSTR = 3'h0;
  localparam logic [15:0] WIDE_ALL_ONES = 16'hffff;
  localparam int PRE_W = 15;
  localparam int SRC_N = 7;

  // ==========================================================
  // Control register carriers
  typedef struct packed {
    logic wide;
    logic [3:0] post_sel;
  } ctrl0_s;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic async_sel;
    logic [3:0] pre_sel;
  } ctrl1_s;

  localparam ctrl0_s RST_CTRL0 = '{wide: 1'b0, post_sel: 4'h0};
  localparam ctrl1_s RST_CTRL1 = '{clk_sel: 3'h0, async_sel: 1'b0, pre_sel: 4'h0};

endpackage : tick_timer_pkg

// >>> design/tick_prescaler.sv
// Power-of-two prescaler, 1:1 up to 1:32768
`timescale 1ns/1ns
module tick_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic [3:0] sel,
  // Ticks
  input wire logic in_tick,
  output logic out_tick
);

  typedef struct packed {
    logic [tick_timer_pkg::PRE_W-1:0] cnt;
  } pre_state_s;

  pre_state_s r;
  pre_state_s n;
  logic [tick_timer_pkg::PRE_W-1:0] mask;

  function automatic logic [tick_timer_pkg::PRE_W-1:0] pre_mask(input logic [3:0] s);
    logic [15:0] one_hot;
    one_hot = 16'h0001 << s;
    return 15'(one_hot - 16'h0001);
  endfunction : pre_mask

  // Select of zero gives an empty mask, so every input tick passes
  assign mask = pre_mask(sel);
  assign out_tick = in_tick & ((r.cnt & mask) == mask);

  always_comb begin
    n = r;
    if (clear) begin
      n.cnt = '0;
    end else if (in_tick) begin
      n.cnt = r.cnt + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pre_bypass;
    (sel == 4'h0) |-> (out_tick == in_tick);
  endproperty
  a_pre_bypass: assert property (p_pre_bypass) else $error("prescaler bypass dropped a tick");

  property p_pre_clear;
    clear |=> (r.cnt == '0);
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

endmodule : tick_prescaler

// >>> design/tick_postscaler.sv
// Postscaler, one output event per 1 to 16 input events
`timescale 1ns/1ns
module tick_postscaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic [3:0] sel,
  // Events
  input wire logic in_ev,
  output logic out_ev
);

  typedef struct packed {
    logic [3:0] cnt;
  } post_state_s;

  post_state_s r;
  post_state_s n;

  assign out_ev = in_ev & (r.cnt == sel);

  always_comb begin
    n = r;
    if (clear) begin
      n.cnt = 4'h0;
    end else if (out_ev) begin
      n.cnt = 4'h0;
    end else if (in_ev) begin
      n.cnt = r.cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_post_clear;
    clear |=> (r.cnt == 4'h0);
  endproperty
  a_post_clear: assert property (p_post_clear) else $error("postscaler not cleared");

  property p_post_one_to_one;
    (sel == 4'h0 && in_ev) |-> out_ev;
  endproperty
  a_post_one_to_one: assert property (p_post_one_to_one) else $error("1:1 postscale missed an event");

endmodule : tick_postscaler

// >>> verif/tick_timer_8_16_tb.sv
// Self-checking testbench for the 8/16-bit tick timer over APB
`timescale 1ns/1ns
module tick_timer_8_16_tb;
  // ==========================================================
  // Signals
  localparam logic [7:0] A_LO = tick_timer_pkg::OFS_COUNT_LOW;
  localparam logic [7:0] A_HI = tick_timer_pkg::OFS_HIGH_PERIOD;
  localparam logic [7:0] A_C0 = tick_timer_pkg::OFS_CTRL_ZERO;
  localparam logic [7:0] A_C1 = tick_timer_pkg::OFS_CTRL_ONE;
  localparam logic [7:0] A_ST = tick_timer_pkg::OFS_STATUS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [tick_timer_pkg::SRC_N-1:0] src_in = '0;
  logic sleep_mode = 1'b0;
  logic tick_output;
  logic match_pulse;
  logic irq_out;
  logic wake_out;
  logic [31:0] ur;
  logic ue;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;

  tick_timer_8_16 u_tick_timer_8_16 (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_in(src_in), .sleep_mode(sleep_mode), .tick_output(tick_output),
    .match_pulse(match_pulse), .irq_out(irq_out), .wake_out(wake_out)
  );

  always #5 pclk = ~pclk;

  // ==========================================================
  // Tasks
  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Data and error are taken at the edge that completes the access
  task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Outputs read right after an edge still hold the values sampled at it
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r);
  endtask : rdc

  // Slow source edges keep sync mode under one count per instruction cycle
  task edges(input int k);
    repeat (k) begin
      @(posedge pclk);
      src_in[0] <= 1'b1;
      repeat (4) @(posedge pclk);
      src_in[0] <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : edges

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc("low", A_LO, 32'h00);
    rdc("high", A_HI, 32'hff);
    rdc("ctrl0", A_C0, 32'h00);
    rdc("ctrl1", A_C1, 32'h00);
    rdc("status", A_ST, 32'h00);
    apb(1'b0, 8'h14, 32'h0, ur, ue);
    chk("unmapped_err", 32'h1, {31'h0, ue});
    chk("unmapped_data", 32'h0, ur);
    wr(A_C1, 32'h20);
    wr(A_HI, 32'h05);
    rdc("period", A_HI, 32'h05);
    wr(A_LO, 32'hfd);
    rdc("low", A_LO, 32'hfd);
    edges(2);
    chk("match_pulse_early", 32'h0, {31'h0, match_pulse});
    rdc("low", A_LO, 32'hff);
    edges(1);
    chk("match_pulse", 32'h1, {31'h0, match_pulse});
    chk("pready_idle", 32'h0, {31'h0, pready});
    rdc("low", A_LO, 32'h00);
    rdc("status", A_ST, 32'h01);
    chk("irq_masked", 32'h0, {31'h0, irq_out});
    rdc("ctrl0", A_C0, 32'h20);
    chk("tick_output_high", 32'h1, {31'h0, tick_output});
    edges(5);
    rdc("low", A_LO, 32'h05);
    edges(1);
    rdc("low", A_LO, 32'h00);
    rdc("ctrl0", A_C0, 32'h00);
    chk("tick_output_low", 32'h0, {31'h0, tick_output});
    wr(A_ST, 32'h01);
    wr(A_C0, 32'h01);
    edges(6);
    rdc("status", A_ST, 32'h00);
    edges(6);
    rdc("status", A_ST, 32'h01);
    rdc("ctrl0", A_C0, 32'h21);
    wr(A_ST, 32'h01);
    wr(A_C1, 32'h22);
    wr(A_LO, 32'h00);
    edges(2);
    wr(A_C1, 32'h22);
    edges(3);
    rdc("low", A_LO, 32'h00);
    edges(1);
    rdc("low", A_LO, 32'h01);
    wr(A_C0, 32'h10);
    wr(A_C1, 32'h20);
    wr(A_HI, 32'h12);
    wr(A_LO, 32'h34);
    rdc("low", A_LO, 32'h34);
    rdc("high", A_HI, 32'h12);
    wr(A_HI, 32'hab);
    rdc("low", A_LO, 32'h34);
    rdc("high", A_HI, 32'h12);
    wr(A_HI, 32'hff);
    wr(A_LO, 32'hfe);
    edges(1);
    rdc("low", A_LO, 32'hff);
    rdc("high", A_HI, 32'hff);
    sleep_mode <= 1'b1;
    edges(1);
    sleep_mode <= 1'b0;
    rdc("low", A_LO, 32'hff);
    wr(A_ST, 32'h03);
    wr(A_C1, 32'h30);
    sleep_mode <= 1'b1;
    edges(1);
    chk("wake", 32'h1, {31'h0, wake_out});
    chk("irq", 32'h1, {31'h0, irq_out});
    sleep_mode <= 1'b0;
    rdc("low", A_LO, 32'h00);
    rdc("high", A_HI, 32'h00);
    rdc("status", A_ST, 32'h03);
    tally_and_finish;
  end
endmodule : tick_timer_8_16_tb
